/* rtl/oinp_defs.svh */
// Notes on behaviour
// - In DIO2 a Status read clears pending, drops INTRQ within 400 ns, enters DIO3.
// - In DIO2 a Device write selecting the other device releases INTRQ, enters DIO4.
// - In DIO2 SERVICE loads the waiting tag, drops INTRQ, resumes that command.
// - In DIO2 another overlapped command drops INTRQ and starts the new command.
// - In DIO3 a Device write selecting the other device enters DIO4 quietly.
// - In DIO3 SERVICE loads the waiting tag and resumes that command.
// - In DIO3 another overlapped command starts the new command directly.
// - Deselected with REL or SERV set enters DIO4; BSY, DRQ zero, INTRQ released.
// - DIO4 select, pending, nIEN zero, REL one, SERV zero: assert INTRQ, enter DIO0.
// - DIO4 select, no pending or nIEN one, REL one, SERV zero: enter DIO1 quietly.
// - DIO4 select, pending, nIEN zero, REL one, SERV one: assert INTRQ, enter DIO2.
// - DIO4 select, no pending or nIEN one, REL one, SERV one: enter DIO3 quietly.
// - A non-data command in DI0, DI1, DIO0 or DIO1 sets BSY and pending within 400 ns, then executes.
// - Completion with nIEN zero sets errors, clears BSY, asserts INTRQ, enters DI0.
// - Completion with nIEN one sets errors, clears BSY, enters DI1 quietly.
// - In DI0 a Status read clears pending, drops INTRQ within 400 ns, enters DI1.
// - In DI0 setting nIEN to one drops INTRQ and enters DI1.
`ifndef OINP_DEFS_SVH
`define OINP_DEFS_SVH
// Register addresses on the plain port.
`define OINP_ADDR_STATUS 3'h0
`define OINP_ADDR_DEVICE 3'h1
`define OINP_ADDR_COMMAND 3'h2
`define OINP_ADDR_DEVCTL 3'h3
`define OINP_ADDR_TAG 3'h4
`define OINP_ADDR_CTRL 3'h5
// Field positions.
`define OINP_DEV_BIT 4
`define OINP_NIEN_BIT 1
`define OINP_CTRL_REL_BIT 0
`define OINP_CTRL_SERV_BIT 1
`define OINP_CTRL_ERR_BIT 2
`define OINP_STS_BSY_BIT 7
`define OINP_STS_DRQ_BIT 3
`define OINP_STS_ERR_BIT 0
// Command codes.
`define OINP_CMD_SERVICE 8'hA2
`define OINP_CMD_NONDATA 8'h00
// Timing.
`define OINP_INTRQ_NS 400
`define OINP_CLK_NS 10
`define OINP_INTRQ_CYC (`OINP_INTRQ_NS / `OINP_CLK_NS)
`define OINP_EXEC_CYC 8
`endif

/* rtl/oinp_pkg.sv */
`default_nettype none
package oinp_pkg;
  typedef enum logic [3:0] {
    OINP_DI0, OINP_DI1, OINP_DI2, OINP_DIO0, OINP_DIO1, OINP_DIO2,
    OINP_DIO3, OINP_DIO4, OINP_DND0, OINP_CMD
  } oinp_state_t;
  // Register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } oinp_req_t;
endpackage
`default_nettype wire

/* rtl/oinp_device.sv */
`include "oinp_defs.svh"
`default_nettype none
module oinp_device #(
  parameter int EXEC_CYCLES = `OINP_EXEC_CYC,
  parameter logic DEV_ID = 1'b0
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire oinp_pkg::oinp_req_t req_in,
  output logic [7:0] rdata_out,
  output logic intrq_out,
  output logic intrq_oe_out,
  output logic [3:0] state_out,
  output logic [7:0] tag_out,
  output logic resume_out,
  output logic new_cmd_out
);
  // Edges from a strobe to the INTRQ flop: one for the state, one for the output.
  localparam int INTRQ_LAT_CYC = 2;

  // Refuse a zero execution count and counts that the eight-bit counter cannot hold.
  if (EXEC_CYCLES < 1 || EXEC_CYCLES > 255) begin : g_bad_exec
    $error("EXEC_CYCLES out of range");
  end

  // Refuse a build whose registered INTRQ path misses the response budget.
  if (INTRQ_LAT_CYC > `OINP_INTRQ_CYC) begin : g_bad_lat
    $error("INTRQ latency exceeds the response budget");
  end

  // ****************************************
  // Decode
  // ****************************************
  logic sts_rd, dev_wr, cmd_wr, dctl_wr, tag_wr, ctrl_wr, sel_other, sel_this;
  logic is_service;

  // True when a strobe is high and the request addresses the given register.
  function automatic logic reg_hit(
    input logic strobe,
    input logic [2:0] addr,
    input logic [2:0] reg_addr
  );
    return strobe && addr == reg_addr;
  endfunction

  // One-cycle register events; the strobes are never both high.
  assign sts_rd = reg_hit(req_in.rd, req_in.addr, `OINP_ADDR_STATUS);
  assign dev_wr = reg_hit(req_in.wr, req_in.addr, `OINP_ADDR_DEVICE);
  assign cmd_wr = reg_hit(req_in.wr, req_in.addr, `OINP_ADDR_COMMAND);
  assign dctl_wr = reg_hit(req_in.wr, req_in.addr, `OINP_ADDR_DEVCTL);
  assign tag_wr = reg_hit(req_in.wr, req_in.addr, `OINP_ADDR_TAG);
  assign ctrl_wr = reg_hit(req_in.wr, req_in.addr, `OINP_ADDR_CTRL);
  assign sel_this = dev_wr && req_in.wdata[`OINP_DEV_BIT] == DEV_ID;
  assign sel_other = dev_wr && req_in.wdata[`OINP_DEV_BIT] != DEV_ID;
  assign is_service = req_in.wdata == `OINP_CMD_SERVICE;

  // ****************************************
  // Flags and state
  // ****************************************
  oinp_pkg::oinp_state_t state_q;
  logic pend_q, rel_q, serv_q, nien_q, err_q, bsy_q, cfg_err_q;
  logic [7:0] wait_tag_q, cnt_q;

  // Device control and the software-visible overlap flags.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      nien_q <= 1'b0;
      rel_q <= 1'b0;
      serv_q <= 1'b0;
      cfg_err_q <= 1'b0;
      wait_tag_q <= 8'h00;
    end else begin
      if (dctl_wr) begin
        nien_q <= req_in.wdata[`OINP_NIEN_BIT];
      end
      if (ctrl_wr) begin
        rel_q <= req_in.wdata[`OINP_CTRL_REL_BIT];
        serv_q <= req_in.wdata[`OINP_CTRL_SERV_BIT];
        cfg_err_q <= req_in.wdata[`OINP_CTRL_ERR_BIT];
      end
      if (tag_wr) begin
        wait_tag_q <= req_in.wdata;
      end
    end
  end

  // Main state walk; INTRQ is only ever derived from the flags below.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state_q <= oinp_pkg::OINP_DI1;
      pend_q <= 1'b0;
      bsy_q <= 1'b0;
      err_q <= 1'b0;
      cnt_q <= 8'h00;
      tag_out <= 8'h00;
      resume_out <= 1'b0;
      new_cmd_out <= 1'b0;
    end else begin
      resume_out <= 1'b0;
      new_cmd_out <= 1'b0;
      unique case (state_q)
        oinp_pkg::OINP_DI0: begin
          if (sts_rd) begin
            pend_q <= 1'b0;
            state_q <= oinp_pkg::OINP_DI1;
          end else if (dctl_wr && req_in.wdata[`OINP_NIEN_BIT]) begin
            state_q <= oinp_pkg::OINP_DI1;
          end else if (sel_other) begin
            // Leaving with an overlap flag set parks in the overlapped deselect state.
            state_q <= (rel_q || serv_q) ? oinp_pkg::OINP_DIO4 : oinp_pkg::OINP_DI2;
          end
        end
        oinp_pkg::OINP_DI1: begin
          if (sel_other) begin
            state_q <= (rel_q || serv_q) ? oinp_pkg::OINP_DIO4 : oinp_pkg::OINP_DI2;
          end
        end
        oinp_pkg::OINP_DI2: begin
          if (sel_this) begin
            state_q <= (pend_q && !nien_q) ? oinp_pkg::OINP_DI0 : oinp_pkg::OINP_DI1;
          end
        end
        oinp_pkg::OINP_DIO0, oinp_pkg::OINP_DIO1: begin
          if (sel_other) begin
            state_q <= oinp_pkg::OINP_DIO4;
          end
        end
        oinp_pkg::OINP_DIO2, oinp_pkg::OINP_DIO3: begin
          if (sts_rd && state_q == oinp_pkg::OINP_DIO2) begin
            pend_q <= 1'b0;
            state_q <= oinp_pkg::OINP_DIO3;
          end else if (sel_other) begin
            state_q <= oinp_pkg::OINP_DIO4;
          end else if (cmd_wr && is_service) begin
            pend_q <= 1'b0;
            tag_out <= wait_tag_q;
            resume_out <= 1'b1;
            state_q <= oinp_pkg::OINP_CMD;
          end else if (cmd_wr) begin
            pend_q <= 1'b0;
            new_cmd_out <= 1'b1;
            state_q <= oinp_pkg::OINP_CMD;
          end
        end
        oinp_pkg::OINP_DIO4: begin
          if (sel_this && rel_q) begin
            if (pend_q && !nien_q) begin
              state_q <= serv_q ? oinp_pkg::OINP_DIO2 : oinp_pkg::OINP_DIO0;
            end else begin
              state_q <= serv_q ? oinp_pkg::OINP_DIO3 : oinp_pkg::OINP_DIO1;
            end
          end
        end
        oinp_pkg::OINP_DND0: begin
          if (cnt_q == 8'h01) begin
            bsy_q <= 1'b0;
            err_q <= cfg_err_q;
            state_q <= nien_q ? oinp_pkg::OINP_DI1 : oinp_pkg::OINP_DI0;
          end
          cnt_q <= cnt_q - 8'h01;
        end
        oinp_pkg::OINP_CMD: begin
          state_q <= oinp_pkg::OINP_DI1;
        end
      endcase
      // A command written in DI0, DI1, DIO0 or DIO1 starts non-data execution.
      if (cmd_wr && state_q inside {oinp_pkg::OINP_DI0, oinp_pkg::OINP_DI1,
          oinp_pkg::OINP_DIO0, oinp_pkg::OINP_DIO1}) begin
        bsy_q <= 1'b1;
        pend_q <= 1'b1;
        err_q <= 1'b0;
        cnt_q <= 8'(EXEC_CYCLES);
        state_q <= oinp_pkg::OINP_DND0;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic intrq_d;
  assign intrq_d = pend_q && !nien_q && (state_q == oinp_pkg::OINP_DI0 ||
    state_q == oinp_pkg::OINP_DIO0 || state_q == oinp_pkg::OINP_DIO2);

  // INTRQ is driven only while selected; deselected it is released.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      intrq_out <= 1'b0;
      intrq_oe_out <= 1'b0;
      state_out <= 4'h0;
    end else begin
      intrq_out <= intrq_d;
      intrq_oe_out <= !(state_q inside {oinp_pkg::OINP_DI2, oinp_pkg::OINP_DIO4});
      state_out <= state_q;
    end
  end

  // Read data one cycle after the strobe.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else if (req_in.rd) begin
      unique case (req_in.addr)
        `OINP_ADDR_STATUS: rdata_out <= {bsy_q, 6'h00, err_q};
        `OINP_ADDR_TAG: rdata_out <= wait_tag_q;
        `OINP_ADDR_CTRL: rdata_out <= {5'h00, cfg_err_q, serv_q, rel_q};
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_dio2_read_quiet: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO2 && sts_rd |-> ##[1:2] !intrq_out)
    else $error("INTRQ held after status read in DIO2");
  a_dio2_desel: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO2 && sel_other && !sts_rd |=> state_q == oinp_pkg::OINP_DIO4
    ##1 !intrq_oe_out)
    else $error("INTRQ not released on deselect");
  a_service_tag: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO3 && cmd_wr && is_service && !sel_other
    |=> resume_out && tag_out == $past(wait_tag_q))
    else $error("Service tag not loaded");
  a_dio4_release: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO4 |=> !intrq_oe_out && !bsy_q)
    else $error("DIO4 drives INTRQ or BSY");
  a_dio4_to_dio0: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO4 && sel_this && rel_q && !serv_q && pend_q && !nien_q
    |=> ##1 intrq_out)
    else $error("INTRQ not asserted on reselect");
  a_dio4_to_dio3: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO4 && sel_this && rel_q && serv_q && nien_q
    |=> state_q == oinp_pkg::OINP_DIO3)
    else $error("Wrong state on quiet reselect");
  a_cmd_busy: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DI1 && cmd_wr |=> bsy_q && pend_q)
    else $error("BSY not set on command");
  a_done_intrq: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DND0 && cnt_q == 8'h01 && !nien_q && !dctl_wr
    |=> !bsy_q ##1 intrq_out)
    else $error("Completion did not raise INTRQ");
  a_di0_nien: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DI0 && dctl_wr && req_in.wdata[`OINP_NIEN_BIT]
    |=> ##1 !intrq_out)
    else $error("nIEN did not drop INTRQ");

  // ****************************************
  // Checks on the overlapped idle states
  // ****************************************
  // Two edges after a trigger: one moves the state, one updates the INTRQ flop.
  sequence s_intrq_low;
    ##2 !intrq_out;
  endsequence
  sequence s_intrq_high;
    ##2 intrq_out;
  endsequence

  // A status read in DIO2 clears pending and parks in DIO3.
  a_dio2_read_state: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO2 && sts_rd
    |=> state_q == oinp_pkg::OINP_DIO3 && !pend_q)
    else $error("Status read in DIO2 did not reach DIO3");
  a_dio2_svc_tag: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO2 && cmd_wr && is_service
    |=> resume_out && tag_out == $past(wait_tag_q))
    else $error("Service in DIO2 did not load the tag");
  a_dio2_cmd_quiet: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO2 && cmd_wr
    |-> s_intrq_low)
    else $error("Command in DIO2 left INTRQ high");
  a_dio2_new_cmd: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO2 && cmd_wr && !is_service
    |=> new_cmd_out && !resume_out)
    else $error("New command in DIO2 not started");
  a_dio3_desel: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO3 && sel_other
    |=> state_q == oinp_pkg::OINP_DIO4 ##1 !intrq_oe_out && !intrq_out)
    else $error("Deselect in DIO3 did not reach DIO4");
  a_dio3_new_cmd: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO3 && cmd_wr && !is_service
    |=> new_cmd_out && state_q == oinp_pkg::OINP_CMD)
    else $error("New command in DIO3 not started");
  a_desel_flags: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q inside {oinp_pkg::OINP_DI0, oinp_pkg::OINP_DI1} && sel_other && (rel_q || serv_q)
    |=> state_q == oinp_pkg::OINP_DIO4)
    else $error("Deselect with overlap flags missed DIO4");
  a_dio4_to_dio1: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO4 && sel_this && rel_q && !serv_q && !(pend_q && !nien_q)
    |=> state_q == oinp_pkg::OINP_DIO1 ##1 !intrq_out)
    else $error("Quiet reselect did not reach DIO1");
  a_dio4_to_dio2: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO4 && sel_this && rel_q && serv_q && pend_q && !nien_q
    |=> state_q == oinp_pkg::OINP_DIO2)
    else $error("Reselect with service did not reach DIO2");
  a_dio4_raise: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DIO4 && sel_this && rel_q && serv_q && pend_q && !nien_q
    |-> s_intrq_high)
    else $error("Reselect with service did not raise INTRQ");

  // ****************************************
  // Checks on non-data execution
  // ****************************************
  // Commands in the released idle states also start execution.
  a_cmd_dio_busy: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q inside {oinp_pkg::OINP_DIO0, oinp_pkg::OINP_DIO1} && cmd_wr
    |=> bsy_q && state_q == oinp_pkg::OINP_DND0)
    else $error("Command in released idle did not start");
  a_done_quiet: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DND0 && cnt_q == 8'h01 && nien_q
    |=> !bsy_q && state_q == oinp_pkg::OINP_DI1)
    else $error("Masked completion did not reach DI1");
  a_di0_read: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DI0 && sts_rd
    |=> !pend_q && state_q == oinp_pkg::OINP_DI1)
    else $error("Status read in DI0 did not reach DI1");
  a_di0_read_quiet: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state_q == oinp_pkg::OINP_DI0 && sts_rd
    |-> s_intrq_low)
    else $error("Status read in DI0 left INTRQ high");
  // INTRQ may only follow a pending, unmasked interrupt.
  a_intrq_flags: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    intrq_out
    |-> $past(pend_q) && !$past(nien_q))
    else $error("INTRQ high without pending unmasked interrupt");
endmodule
`default_nettype wire

/* sim/oinp_host_model.sv */
`include "oinp_defs.svh"
`default_nettype none
// ****
// Host side of the non-data command handshake.
// ****
module oinp_host_model (
  input wire logic core_clk_in,
  input wire logic go_in,
  input wire logic nien_in,
  input wire logic intrq_in,
  input wire logic [7:0] rdata_in,
  output var oinp_pkg::oinp_req_t req_out,
  output logic busy_out,
  output logic [7:0] sts_out,
  output logic [7:0] reads_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;
  // The bus is idle and no status is known before the first command.
  initial begin
    req_out = '0;
    busy_out = 1'b0;
    sts_out = 8'h00;
    reads_out = 8'h00;
  end
  // Write one command, wait for the interrupt or the settle time, then poll status.
  always @(posedge go_in) begin
    busy_out <= 1'b1;
    reads_out = 8'h00;
    sts_out = 8'h80;
    @(posedge core_clk_in);
    req_out <= '{1'b1, 1'b0, `OINP_ADDR_COMMAND, `OINP_CMD_NONDATA};
    @(posedge core_clk_in);
    req_out <= '0;
    if (!nien_in) begin
      for (n = 0; n < 300 && intrq_in !== 1'b1; n++) @(posedge core_clk_in);
    end else begin
      repeat (40) @(posedge core_clk_in);
    end
    for (n = 0; n < 100 && sts_out[`OINP_STS_BSY_BIT] !== 1'b0; n++) begin
      req_out <= '{1'b0, 1'b1, `OINP_ADDR_STATUS, 8'h00};
      @(posedge core_clk_in);
      req_out <= '0;
      @(posedge core_clk_in);
      sts_out = rdata_in;
      reads_out = reads_out + 8'h01;
    end
    busy_out <= 1'b0;
  end
endmodule
`default_nettype wire

/* sim/tb_overlap_idle_nondata_protocol.sv */
`include "oinp_defs.svh"
`default_nettype none
module tb_overlap_idle_nondata_protocol;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Signals and the device under test.
  // ****
  typedef struct packed {
    logic [2:0] a;
    logic [7:0] d;
    logic [3:0] s;
    logic oe;
  } oinp_row_t;
  logic core_clk_in, resetn_in, go, nien, hbusy, intrq, oe, resume, newc;
  logic [7:0] hsts, hreads, rdata, tag;
  logic [3:0] state;
  oinp_pkg::oinp_req_t treq, hreq;
  int fails, checked, n;
  oinp_row_t rows [6];
  oinp_device #(.EXEC_CYCLES(60), .DEV_ID(1'b0)) u_dut (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .req_in(hbusy ? hreq : treq),
    .rdata_out(rdata), .intrq_out(intrq), .intrq_oe_out(oe), .state_out(state),
    .tag_out(tag), .resume_out(resume), .new_cmd_out(newc));
  oinp_host_model u_host (
    .core_clk_in(core_clk_in), .go_in(go), .nien_in(nien), .intrq_in(intrq),
    .rdata_in(rdata), .req_out(hreq), .busy_out(hbusy), .sts_out(hsts), .reads_out(hreads));
  // Free-running core clock.
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // ****
  // Shared tasks.
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    treq <= '{w, ~w, a, d};
    @(posedge core_clk_in);
    treq <= '0;
  endtask
  task automatic st(input logic [3:0] s, input logic i, input logic o);
    repeat (3) @(posedge core_clk_in);
    #1;
    chk({4'h0, state}, {4'h0, s});
    chk({6'h0, intrq, oe}, {6'h0, i, o});
    $display("test step done at %0t", $time);
  endtask
  task automatic do_reset();
    @(posedge core_clk_in);
    resetn_in <= 1'b0;
    nien <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    resetn_in <= 1'b1;
  endtask
  task automatic wait_for(input int which);
    for (n = 0; n < 400 && (which ? hbusy !== 1'b0 : intrq !== 1'b1); n++) begin
      @(posedge core_clk_in);
    end
    if (n == 400) begin
      chk(8'h00, 8'h01);
      final_report();
    end
  endtask
  // Reach DI0 by a non-data command, then write the given release and service flags.
  task automatic to_di0(input logic [7:0] c);
    do_reset();
    bus(1'b1, `OINP_ADDR_TAG, 8'h5A);
    bus(1'b1, `OINP_ADDR_COMMAND, `OINP_CMD_NONDATA);
    wait_for(0);
    bus(1'b1, `OINP_ADDR_CTRL, c);
  endtask
  task automatic to_sel(input logic [7:0] c);
    to_di0(c);
    bus(1'b1, `OINP_ADDR_DEVICE, 8'h10);
    st(4'h7, 1'b0, 1'b0);
    bus(1'b1, `OINP_ADDR_DEVICE, 8'h00);
  endtask
  task automatic kick(input logic ni);
    @(posedge core_clk_in);
    nien <= ni;
    go <= 1'b1;
    @(posedge core_clk_in);
    go <= 1'b0;
  endtask
  task automatic pulses(input logic nc);
    logic rs;
    logic ns;
    rs = 1'b0;
    ns = 1'b0;
    repeat (4) begin
      #1;
      rs = rs | resume;
      ns = ns | newc;
      @(posedge core_clk_in);
    end
    #1;
    chk({6'h0, rs, ns}, {6'h0, ~nc, nc});
    chk({7'h0, intrq}, 8'h00);
    if (!nc) chk(tag, 8'h5A);
  endtask
  // ****
  // Main sequence: table rows first, then hand-written cases.
  // ****
  initial begin
    resetn_in = 1'b0;
    treq = '0;
    go = 1'b0;
    nien = 1'b0;
    fails = 0;
    checked = 0;
    rows = '{'{`OINP_ADDR_CTRL, 8'h03, 4'h1, 1'b1}, '{`OINP_ADDR_DEVICE, 8'h10, 4'h7, 1'b0},
      '{`OINP_ADDR_DEVICE, 8'h00, 4'h6, 1'b1}, '{`OINP_ADDR_DEVICE, 8'h10, 4'h7, 1'b0},
      '{`OINP_ADDR_CTRL, 8'h01, 4'h7, 1'b0}, '{`OINP_ADDR_DEVICE, 8'h00, 4'h4, 1'b1}};
    do_reset();
    st(4'h1, 1'b0, 1'b1);
    chk(tag, 8'h00);
    foreach (rows[k]) begin
      bus(1'b1, rows[k].a, rows[k].d);
      st(rows[k].s, 1'b0, rows[k].oe);
    end
    do_reset();
    kick(1'b0);
    for (n = 0; n < 40 && state !== 4'h8; n++) @(posedge core_clk_in);
    chk({4'h0, state}, 8'h08);
    wait_for(1);
    chk(hsts & 8'h81, 8'h00);
    chk(hreads, 8'h01);
    st(4'h1, 1'b0, 1'b1);
    do_reset();
    bus(1'b1, `OINP_ADDR_CTRL, 8'h04);
    bus(1'b1, `OINP_ADDR_DEVCTL, 8'h02);
    kick(1'b1);
    wait_for(1);
    chk(hsts & 8'h81, 8'h01);
    chk({7'h0, hreads > 8'h01}, 8'h01);
    st(4'h1, 1'b0, 1'b1);
    to_sel(8'h03);
    st(4'h5, 1'b1, 1'b1);
    bus(1'b0, `OINP_ADDR_STATUS, 8'h00);
    st(4'h6, 1'b0, 1'b1);
    to_sel(8'h03);
    bus(1'b1, `OINP_ADDR_DEVICE, 8'h10);
    st(4'h7, 1'b0, 1'b0);
    to_sel(8'h01);
    st(4'h3, 1'b1, 1'b1);
    to_di0(8'h00);
    bus(1'b1, `OINP_ADDR_DEVICE, 8'h10);
    st(4'h2, 1'b0, 1'b0);
    bus(1'b1, `OINP_ADDR_DEVICE, 8'h00);
    st(4'h0, 1'b1, 1'b1);
    bus(1'b1, `OINP_ADDR_DEVCTL, 8'h02);
    st(4'h1, 1'b0, 1'b1);
    for (int j = 0; j < 4; j++) begin
      to_sel(8'h03);
      if (j[1]) bus(1'b0, `OINP_ADDR_STATUS, 8'h00);
      bus(1'b1, `OINP_ADDR_COMMAND, j[0] ? 8'h11 : `OINP_CMD_SERVICE);
      pulses(j[0]);
    end
    final_report();
  end
endmodule
`default_nettype wire
